// ---- src/mfts_pkg.sv ----
// Package of constants and types for the modem frame task sequencer
package mfts_pkg;

  // ==========================================================================
  // Clock and bit rate
  // ==========================================================================
  localparam int unsigned CLK_HZ      = 10000000;
  localparam int unsigned BIT_RATE_HZ = 8000;
  localparam int unsigned BIT_CYCLES  = CLK_HZ / BIT_RATE_HZ;
  localparam logic [10:0] BIT_DIV_MAX = 11'(BIT_CYCLES - 1);

  // ==========================================================================
  // Task codes written by the host
  // ==========================================================================
  typedef enum logic [2:0] {
    TASK_NULL   = 3'h0,
    TASK_HEAD   = 3'h1,  // frame_head_send_task
    TASK_DATA   = 3'h2,  // data_block_send_task
    TASK_SINGLE = 3'h3,  // single_byte_send_task
    TASK_SYNC   = 3'h4,  // sync_byte_load_task
    TASK_HSRCH  = 3'h5,  // head_search_task
    TASK_SSRCH  = 3'h6,  // sync_search_task
    TASK_RXDATA = 3'h7   // data_block_receive_task
  } mfts_task_t;

  // ==========================================================================
  // Byte counts and bit-period figures
  // ==========================================================================
  localparam logic [4:0] HEAD_BYTES   = 5'h06;
  localparam logic [4:0] DATA_BYTES   = 5'h12;
  localparam logic [4:0] SINGLE_BYTES = 5'h01;
  localparam logic [4:0] SYNC_BYTES   = 5'h02;
  localparam logic [4:0] HEAD_CTRL_RX = 5'h02;
  localparam logic [4:0] RX_BLOCK_LEN = 5'h12;
  localparam logic [7:0] SETTLE_BITS  = 8'h02;
  localparam logic [7:0] SRCH_WAIT    = 8'h0C;
  localparam logic [7:0] LEV_CLAMP    = 8'h01;
  localparam logic [7:0] LEV_WINDOW   = 8'h1C;
  localparam logic [7:0] LEV_TIMEOUT  = 8'h1E;
  localparam logic [7:0] CLK_WINDOW   = 8'h0E;
  localparam logic [7:0] CLK_WIDE     = 8'h10;
  localparam logic [7:0] CLK_MEDIUM   = 8'h1E;
  localparam logic [7:0] HANG_BYTE    = 8'h33;
  localparam logic [7:0] TX_BYTE_BITS = 8'h08;
  localparam logic [3:0] RX_HEAD_BITS = 4'h8;

  // ==========================================================================
  // Level and clock loop modes
  // ==========================================================================
  typedef enum logic [1:0] {
    LEV_IDLE  = 2'h0,
    LEV_CLAMP_M = 2'h1,
    LEV_LOSSY = 2'h2,
    LEV_RESID = 2'h3
  } mfts_lev_t;

  typedef enum logic [1:0] {
    LRES_LOSSY = 2'h0,
    LRES_AVG   = 2'h1,
    LRES_HOLD  = 2'h2
  } mfts_lres_t;

  typedef enum logic [1:0] {
    BW_WIDE   = 2'h0,
    BW_MEDIUM = 2'h1,
    BW_RESID  = 2'h2
  } mfts_bw_t;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage : mfts_pkg

// ---- src/mfts_if.sv ----
// Interface joining the modem sequencer and its host controller
`timescale 1ns/1ps
interface mfts_if;
  logic       task_wr;     // Task write strobe, one cycle
  logic [2:0] task_code;   // Task written with the strobe
  logic       lev_acq;     // level_acquire_cmd with the task
  logic       clk_acq;     // clock_acquire_cmd with the task
  logic       buf_wr;      // Host loads a byte into the data buffer
  logic       buf_rd;      // Host reads a byte from the data buffer
  logic [7:0] buf_wdata;
  logic [7:0] buf_rdata;
  logic       stat_rd;     // Status read strobe
  logic [7:0] status;      // Status byte
  logic       irq;         // Interrupt, level, cleared by status read
  logic       frame_sync;  // Frame sync found (receive)

  modport modem (input task_wr, task_code, lev_acq, clk_acq, buf_wr, buf_rd,
                 buf_wdata, stat_rd, frame_sync,
                 output buf_rdata, status, irq);
  modport host (output task_wr, task_code, lev_acq, clk_acq, buf_wr,
                buf_rd, buf_wdata, stat_rd, frame_sync,
                input buf_rdata, status, irq);
endinterface : mfts_if

// ---- src/mfts_bit_timer.sv ----
// Bit-period enable divider shared by both ends
`timescale 1ns/1ps
module mfts_bit_timer (
  input  wire logic I_SYS_CLK,
  input  wire logic I_RST,
  input  wire logic i_restart,
  output logic      o_bit_en
);
  logic [10:0] div_q;

  // ==========================================================================
  // Divider
  // ==========================================================================
  // One-cycle pulse per bit period, realigned on restart
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_q <= 11'h000;
    end else if (i_restart || div_q == mfts_pkg::BIT_DIV_MAX) begin
      div_q <= 11'h000;
    end else begin
      div_q <= div_q + 11'h001;
    end
  end

  assign o_bit_en = (div_q == mfts_pkg::BIT_DIV_MAX);
endmodule : mfts_bit_timer

// ---- src/mfts_modem.sv ----
// Modem end: task sequencer and acquisition control
`timescale 1ns/1ps
module mfts_modem (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST,
  mfts_if.modem           bus,
  input  wire logic       I_TX_MODE,
  input  wire logic [1:0] I_LEVEL_RESIDUAL_MODE,
  input  wire logic [1:0] I_CLOCK_LOOP_BANDWIDTH,
  output logic            o_tx_bit,
  output logic [1:0]      o_level_mode,
  output logic [1:0]      o_level_residual,
  output logic [1:0]      o_bw_mode,
  output logic [1:0]      o_bw_residual,
  output logic            o_idle
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_TX    = 3'h1,
    ST_RXSYN = 3'h2,
    ST_SRCH  = 3'h3,
    ST_RXHD  = 3'h4,
    ST_RXBLK = 3'h5
  } mfts_st_t;

  mfts_st_t               st_q;
  mfts_pkg::mfts_lev_t    lev_q;
  mfts_pkg::mfts_bw_t     bw_q;
  logic [7:0]             mem_q [0:31];
  logic [4:0]             wp_q;
  logic [4:0]             rp_q;
  logic [4:0]             need_q;
  logic [7:0]             shift_q;
  logic [7:0]             bitc_q;
  logic                   bits_q;
  logic [7:0]             levc_q;
  logic [7:0]             bwc_q;
  logic                   lev_srch_q;
  logic                   bw_srch_q;
  logic                   irq_q;
  logic                   empty_q;
  logic                   err_q;
  logic [7:0]             rdata_q;
  logic                   bit_en;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire logic tw        = bus.task_wr;
  wire logic is_tx     = tw && (bus.task_code == mfts_pkg::TASK_HEAD ||
                                bus.task_code == mfts_pkg::TASK_DATA ||
                                bus.task_code == mfts_pkg::TASK_SINGLE);
  wire logic is_srch   = tw && (bus.task_code == mfts_pkg::TASK_HSRCH ||
                                bus.task_code == mfts_pkg::TASK_SSRCH);
  wire logic is_sync   = tw && bus.task_code == mfts_pkg::TASK_SYNC;
  wire logic is_rxblk  = tw && bus.task_code == mfts_pkg::TASK_RXDATA;
  // Next byte loads as the last bit of the one before ends: no gap bit
  wire logic take_tx   = st_q == ST_TX && bit_en &&
                         (!bits_q || bitc_q == 8'h01) && rp_q != need_q;
  wire logic take_sync = st_q == ST_RXSYN && bit_en && rp_q != need_q;
  wire logic last_take = (take_tx || take_sync) &&
                         (rp_q + 5'h01 == need_q);
  wire logic tx_drain  = st_q == ST_TX && bit_en && bits_q &&
                         bitc_q == 8'h01 && rp_q == need_q;
  wire logic sync_hit  = st_q == ST_SRCH && bus.frame_sync;
  wire logic rx_done   = (st_q == ST_RXHD || st_q == ST_RXBLK) && bit_en &&
                         bitc_q == 8'h00;
  // Realign bit timing only on acquire commands or a transmit from idle,
  // so a later task write does not stretch a bit in flight
  wire logic bit_restart = tw && (bus.lev_acq || bus.clk_acq ||
                                  (is_tx && st_q == ST_IDLE));

  // Task load length by code
  function automatic logic [4:0] task_len(input logic [2:0] c);
    unique case (c)
      mfts_pkg::TASK_HEAD:   task_len = mfts_pkg::HEAD_BYTES;
      mfts_pkg::TASK_DATA:   task_len = mfts_pkg::DATA_BYTES;
      mfts_pkg::TASK_SINGLE: task_len = mfts_pkg::SINGLE_BYTES;
      mfts_pkg::TASK_SYNC:   task_len = mfts_pkg::SYNC_BYTES;
      default:               task_len = 5'h00;
    endcase
  endfunction

  mfts_bit_timer u_bit (
    .I_SYS_CLK (I_SYS_CLK),
    .I_RST     (I_RST),
    .i_restart (bit_restart),
    .o_bit_en  (bit_en)
  );

  // ==========================================================================
  // Data buffer
  // ==========================================================================
  // Host writes bytes; a new task restarts reading at the head
  always_ff @(posedge I_SYS_CLK) begin
    if (bus.buf_wr) begin
      mem_q[wp_q] <= bus.buf_wdata;
    end
  end

  // Pointers and read data
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      wp_q    <= 5'h00;
      rp_q    <= 5'h00;
      need_q  <= 5'h00;
      rdata_q <= mfts_pkg::BYTE_RST;
    end else begin
      if (tw) begin
        wp_q   <= 5'h00;
        rp_q   <= 5'h00;
        need_q <= task_len(bus.task_code);
      end else begin
        if (bus.buf_wr) wp_q <= wp_q + 5'h01;
        if (take_tx || take_sync || bus.buf_rd) rp_q <= rp_q + 5'h01;
      end
      rdata_q <= mem_q[rp_q];
    end
  end

  // ==========================================================================
  // Task sequencer
  // ==========================================================================
  // Main state, bit shifting and receive counters
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q    <= ST_IDLE;
      shift_q <= mfts_pkg::BYTE_RST;
      bitc_q  <= 8'h00;
      bits_q  <= 1'b0;
    end else if (tw) begin
      if (!is_tx) bits_q <= 1'b0;  // A non-transmit task drops a byte in flight
      unique case (1'b1)
        is_tx:    st_q <= ST_TX;
        is_sync:  st_q <= ST_RXSYN;
        is_srch:  st_q <= ST_SRCH;
        is_rxblk: begin
          st_q   <= ST_RXBLK;
          bitc_q <= {3'h0, mfts_pkg::RX_BLOCK_LEN} << 3;
        end
        default:  st_q <= ST_IDLE;
      endcase
    end else begin
      if (take_tx) begin
        shift_q <= mem_q[rp_q];
        bitc_q  <= mfts_pkg::TX_BYTE_BITS;
        bits_q  <= 1'b1;
      end else if (st_q == ST_TX && bit_en && bits_q) begin
        shift_q <= {shift_q[6:0], 1'b0};
        bitc_q  <= bitc_q - 8'h01;
        bits_q  <= bitc_q != 8'h01;
        if (tx_drain) st_q <= ST_IDLE;
      end
      if (st_q == ST_RXSYN && last_take) st_q <= ST_IDLE;
      if (sync_hit) begin
        st_q   <= ST_RXHD;
        bitc_q <= {3'h0, mfts_pkg::HEAD_CTRL_RX} << 3;
      end
      if ((st_q == ST_RXHD || st_q == ST_RXBLK) && bit_en) begin
        bitc_q <= bitc_q - 8'h01;
        if (bitc_q == 8'h00) st_q <= ST_IDLE;
      end
    end
  end

  // ==========================================================================
  // Interrupt and status
  // ==========================================================================
  // Set beats the status read clear
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_q   <= 1'b0;
      empty_q <= 1'b1;
      err_q   <= 1'b0;
    end else begin
      if (last_take) irq_q <= 1'b1;
      else if (rx_done) irq_q <= 1'b1;
      else if (tx_drain && I_TX_MODE) irq_q <= 1'b1;
      else if (bus.stat_rd) irq_q <= 1'b0;
      if (tx_drain && I_TX_MODE) empty_q <= 1'b1;
      else if (tw && bus.task_code != mfts_pkg::TASK_NULL) empty_q <= 1'b0;
      if (!I_TX_MODE && rx_done) err_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Level acquisition
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      lev_q      <= mfts_pkg::LEV_IDLE;
      levc_q     <= 8'h00;
      lev_srch_q <= 1'b0;
    end else if (tw && bus.lev_acq) begin
      lev_q      <= mfts_pkg::LEV_CLAMP_M;
      levc_q     <= 8'h00;
      lev_srch_q <= is_srch;
    end else begin
      if (bit_en && lev_q != mfts_pkg::LEV_IDLE &&
          lev_q != mfts_pkg::LEV_RESID && levc_q != 8'hFF) begin
        levc_q <= levc_q + 8'h01;
      end
      if (is_srch && lev_q != mfts_pkg::LEV_RESID &&
          levc_q < mfts_pkg::LEV_WINDOW) begin
        lev_srch_q <= 1'b1;
      end
      if (lev_q == mfts_pkg::LEV_CLAMP_M && bit_en &&
          levc_q + 8'h01 == mfts_pkg::LEV_CLAMP) begin
        lev_q <= mfts_pkg::LEV_LOSSY;
      end else if (lev_q == mfts_pkg::LEV_LOSSY) begin
        if (lev_srch_q && sync_hit) begin
          lev_q <= mfts_pkg::LEV_RESID;
        end else if (!lev_srch_q && bit_en &&
                     levc_q + 8'h01 == mfts_pkg::LEV_TIMEOUT) begin
          lev_q <= mfts_pkg::LEV_RESID;
        end
      end
    end
  end

  // ==========================================================================
  // Clock loop bandwidth
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      bw_q      <= mfts_pkg::BW_RESID;
      bwc_q     <= 8'h00;
      bw_srch_q <= 1'b0;
    end else if (tw && bus.clk_acq) begin
      bw_q      <= mfts_pkg::BW_WIDE;
      bwc_q     <= 8'h00;
      bw_srch_q <= is_srch;
    end else begin
      if (bit_en && bw_q != mfts_pkg::BW_RESID) bwc_q <= bwc_q + 8'h01;
      if (is_srch && bw_q == mfts_pkg::BW_WIDE &&
          bwc_q < mfts_pkg::CLK_WINDOW) begin
        bw_srch_q <= 1'b1;
      end
      if (bw_q == mfts_pkg::BW_WIDE) begin
        if ((bw_srch_q && sync_hit) || (!bw_srch_q && bit_en &&
            bwc_q + 8'h01 == mfts_pkg::CLK_WIDE)) begin
          bw_q  <= mfts_pkg::BW_MEDIUM;
          bwc_q <= 8'h00;
        end
      end else if (bw_q == mfts_pkg::BW_MEDIUM && bit_en &&
                   bwc_q + 8'h01 == mfts_pkg::CLK_MEDIUM) begin
        bw_q <= mfts_pkg::BW_RESID;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign bus.irq          = irq_q;
  assign bus.buf_rdata    = rdata_q;
  assign bus.status       = {1'b0, irq_q, empty_q && I_TX_MODE, 1'b0,
                             err_q, 3'h0};
  assign o_tx_bit         = shift_q[7];
  assign o_level_mode     = lev_q;
  assign o_level_residual = I_LEVEL_RESIDUAL_MODE;
  assign o_bw_mode        = bw_q;
  assign o_bw_residual    = I_CLOCK_LOOP_BANDWIDTH;
  assign o_idle           = st_q == ST_IDLE;
endmodule : mfts_modem

// ---- src/mfts_host.sv ----
// Host end: issues transmit and receive task sequences
`timescale 1ns/1ps
module mfts_host (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST,
  mfts_if.host            bus,
  input  wire logic       I_START_TX,
  input  wire logic       I_START_RX,
  input  wire logic [7:0] I_DATA,
  input  wire logic       I_SYNC_FOUND,
  output logic            o_busy
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_LOAD = 3'h1, H_WAIT = 3'h2, H_TASK = 3'h3,
    H_IRQ  = 3'h4
  } mfts_hst_t;

  mfts_hst_t  st_q;
  logic [2:0] step_q;
  logic [4:0] cnt_q;
  logic [7:0] wait_q;
  logic       bit_en;

  // Step sequence: 0 head,1 data,2 hang; 4 sync,5 search,6 rx block
  wire logic [4:0] len = step_q == 3'h0 ? mfts_pkg::HEAD_BYTES :
                         step_q == 3'h1 ? mfts_pkg::DATA_BYTES :
                         step_q == 3'h2 ? mfts_pkg::SINGLE_BYTES :
                         step_q == 3'h4 ? mfts_pkg::SYNC_BYTES : 5'h00;
  wire logic [2:0] code = step_q == 3'h0 ? mfts_pkg::TASK_HEAD :
                          step_q == 3'h1 ? mfts_pkg::TASK_DATA :
                          step_q == 3'h2 ? mfts_pkg::TASK_SINGLE :
                          step_q == 3'h4 ? mfts_pkg::TASK_SYNC :
                          step_q == 3'h5 ? mfts_pkg::TASK_HSRCH :
                          mfts_pkg::TASK_RXDATA;

  // Waits count whole bit periods from the end of the byte load
  wire logic wait_go = st_q == H_LOAD && cnt_q == len;

  mfts_bit_timer u_bit (
    .I_SYS_CLK (I_SYS_CLK),
    .I_RST     (I_RST),
    .i_restart (wait_go),
    .o_bit_en  (bit_en)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q   <= H_IDLE;
      step_q <= 3'h0;
      cnt_q  <= 5'h00;
      wait_q <= 8'h00;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          cnt_q <= 5'h00;
          if (I_START_TX) begin
            step_q <= 3'h0;
            st_q   <= H_LOAD;
          end else if (I_START_RX) begin
            step_q <= 3'h4;
            st_q   <= H_LOAD;
          end
        end
        H_LOAD: begin
          if (cnt_q == len) begin
            st_q   <= H_WAIT;
            wait_q <= step_q == 3'h5 ? mfts_pkg::SRCH_WAIT
                                     : mfts_pkg::SETTLE_BITS;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        H_WAIT: begin
          if (wait_q == 8'h00) st_q <= H_TASK;
          else if (bit_en) wait_q <= wait_q - 8'h01;
        end
        H_TASK: st_q <= H_IRQ;
        H_IRQ: begin
          if (bus.irq) begin
            cnt_q <= 5'h00;
            unique case (step_q)
              3'h0: begin step_q <= 3'h1; st_q <= H_LOAD; end
              3'h1: begin step_q <= 3'h2; st_q <= H_LOAD; end
              3'h4: begin step_q <= 3'h5; st_q <= H_LOAD; end
              3'h5: begin step_q <= 3'h6; st_q <= H_LOAD; end
              default: st_q <= H_IDLE;
            endcase
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Strobes: status read clears the pending interrupt
  assign bus.buf_wr     = st_q == H_LOAD && cnt_q != len;
  assign bus.buf_wdata  = step_q == 3'h2 ? mfts_pkg::HANG_BYTE : I_DATA;
  assign bus.task_wr    = st_q == H_TASK;
  assign bus.task_code  = code;
  assign bus.lev_acq    = st_q == H_TASK && step_q == 3'h4;
  assign bus.clk_acq    = st_q == H_TASK && step_q == 3'h4;
  assign bus.stat_rd    = st_q == H_IRQ && bus.irq;
  assign bus.buf_rd     = 1'b0;
  assign bus.frame_sync = I_SYNC_FOUND;
  assign o_busy         = st_q != H_IDLE;
endmodule : mfts_host

// ---- verification/mfts_checker.sv ----
// Checker of the task interface between the modem and host ends
`timescale 1ns/1ps
module mfts_checker (
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST,
  input wire logic       task_wr,
  input wire logic [2:0] task_code,
  input wire logic       lev_acq,
  input wire logic       clk_acq,
  input wire logic       buf_wr,
  input wire logic       stat_rd,
  input wire logic [7:0] status,
  input wire logic       irq
);
  localparam int B = mfts_pkg::BIT_CYCLES;
  logic [4:0]  nb_q;   // Bytes loaded since the last task
  logic [15:0] gap_q;  // Cycles since the last byte load
  logic [15:0] sgap_q; // Cycles since the last status read

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  // ==================
  // Helper counters
  // ==================
  // Byte count and saturating gap counts
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      nb_q   <= 5'h00;
      gap_q  <= 16'h0000;
      sgap_q <= 16'h0000;
    end else begin
      nb_q   <= task_wr ? 5'h00 : nb_q + 5'(buf_wr);
      gap_q  <= buf_wr ? 16'h0000 : gap_q + 16'(gap_q != 16'hFFFF);
      sgap_q <= stat_rd ? 16'h0000 : sgap_q + 16'(sgap_q != 16'hFFFF);
    end
  end

  // ==================
  // Assertions
  // ==================
  // A task write of one given code
  sequence s_task(logic [2:0] c);
    task_wr && task_code == c;
  endsequence

  AST_HEAD_BYTES: assert property (s_task(mfts_pkg::TASK_HEAD) |->
    nb_q == mfts_pkg::HEAD_BYTES) else $error("head byte count");
  AST_HEAD_SETTLE: assert property (s_task(mfts_pkg::TASK_HEAD) |->
    gap_q >= 16'(2 * B)) else $error("head task before settle");
  AST_DATA_BYTES: assert property (s_task(mfts_pkg::TASK_DATA) |->
    nb_q == mfts_pkg::DATA_BYTES) else $error("data byte count");
  AST_SYNC_BYTES: assert property (s_task(mfts_pkg::TASK_SYNC) |->
    nb_q == mfts_pkg::SYNC_BYTES) else $error("sync byte count");
  AST_SYNC_ACQ: assert property (s_task(mfts_pkg::TASK_SYNC) |->
    lev_acq && clk_acq) else $error("acquire commands missing");
  AST_SRCH_WAIT: assert property (s_task(mfts_pkg::TASK_HSRCH) |->
    sgap_q >= 16'(12 * B)) else $error("search task too early");
  AST_IRQ_STANDS: assert property (irq && !stat_rd |=> irq)
    else $error("interrupt dropped before status read");
  AST_STAT_IRQ: assert property ($rose(irq) |-> ##[0:1] status[6])
    else $error("status does not show interrupt");
endmodule // mfts_checker

// ---- verification/mfts_tb.sv ----
// Testbench joining the modem and host ends of the sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("[ERR] %0t ns: value mismatch", $time); end end
module mfts_tb;
  localparam int B = mfts_pkg::BIT_CYCLES;
  // First head byte is taken one bit after the task, then one per byte
  localparam int HEAD_IRQ_BITS =
    (mfts_pkg::HEAD_BYTES - 1) * mfts_pkg::TX_BYTE_BITS + 1;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       start_tx = 1'b0;
  logic       start_rx = 1'b0;
  logic       sync_found = 1'b0;
  logic       tx_mode = 1'b1;
  logic [7:0] din = 8'h00;
  logic [1:0] lres = 2'h0;
  logic [1:0] lbw = 2'h0;
  logic [1:0] lev, lev_p, lev_res, bw, bw_p, bw_res;
  logic       idle;
  logic       tx_bit;
  logic [7:0] b0 = 8'h00;
  logic [1:0] lev_x, bw_x;
  logic [4:0] nb = 5'h00;
  logic [7:0] q[$];
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         t0, t_acq = 0;
  int         t_srch = 32'h3FFFFFFF;

  mfts_if u_mfts_if ();
  mfts_modem u_mfts_modem (.I_SYS_CLK(clk), .I_RST(rst), .bus(u_mfts_if),
    .I_TX_MODE(tx_mode), .I_LEVEL_RESIDUAL_MODE(lres),
    .I_CLOCK_LOOP_BANDWIDTH(lbw), .o_tx_bit(tx_bit), .o_level_mode(lev),
    .o_level_residual(lev_res), .o_bw_mode(bw), .o_bw_residual(bw_res),
    .o_idle(idle));
  mfts_host u_mfts_host (.I_SYS_CLK(clk), .I_RST(rst), .bus(u_mfts_if),
    .I_START_TX(start_tx), .I_START_RX(start_rx), .I_DATA(din),
    .I_SYNC_FOUND(sync_found), .o_busy());
  mfts_checker u_mfts_checker (.I_SYS_CLK(clk), .I_RST(rst),
    .task_wr(u_mfts_if.task_wr), .task_code(u_mfts_if.task_code),
    .lev_acq(u_mfts_if.lev_acq), .clk_acq(u_mfts_if.clk_acq),
    .buf_wr(u_mfts_if.buf_wr), .stat_rd(u_mfts_if.stat_rd),
    .status(u_mfts_if.status), .irq(u_mfts_if.irq));

  // ==================
  // Clock, data and helpers
  // ==================
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) din <= 8'($urandom);

  // Elapsed cycles fall on bit count b
  function automatic logic near(int e, int b);
    return e >= b * B && e <= b * B + 3;
  endfunction

  // Wait at falling edges until a task write shows
  task automatic wait_task(int lim);
    for (int i = 0; i < lim && !u_mfts_if.task_wr; i++) @(negedge clk);
    t0 = cyc;
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==================
  // Monitors
  // ==================
  // Take the oldest note at each task write and compare it
  always @(posedge clk) begin
    lev_p <= lev;
    bw_p <= bw;
    if (rst) nb <= 5'h00;
    else if (u_mfts_if.task_wr) begin
      nb <= 5'h00;
      if (q.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK({u_mfts_if.task_code, nb}, q.pop_front())
      if (u_mfts_if.task_code == mfts_pkg::TASK_SYNC) t_acq = cyc;
      if (u_mfts_if.task_code == mfts_pkg::TASK_HSRCH) t_srch = cyc;
    end else if (u_mfts_if.buf_wr) nb <= nb + 5'h01;
    if (u_mfts_if.buf_wr && nb == 5'h00) b0 <= u_mfts_if.buf_wdata;
    // Mode steps land on their bit counts
    if (!rst && t_acq > 0 && !sync_found && lev !== lev_p)
      `CHK(near(cyc - t_acq, lev == 2'h1 ? 0 : lev == 2'h2 ? 1 : 30), 1'b1)
    if (!rst && t_acq > 0 && !sync_found && bw !== bw_p)
      `CHK(near(cyc - t_acq, bw[1] ? 46 : bw[0] ? 16 : 0), 1'b1)
  end

  // Watchdog over the expected run length
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // ==================
  // Main sequence
  // ==================
  initial begin
    void'($urandom(95));
    q.push_back({mfts_pkg::TASK_HEAD, mfts_pkg::HEAD_BYTES});
    q.push_back({mfts_pkg::TASK_DATA, mfts_pkg::DATA_BYTES});
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) `CHK(idle, 1'b1)
    @(posedge clk) start_tx <= 1'b1;
    @(posedge clk) start_tx <= 1'b0;
    wait_task(20000);
    // First head byte leaves MSB first, sampled mid-bit
    for (int i = 7; i >= 0; i--) begin
      repeat (i == 7 ? 3 * B / 2 : B) @(negedge clk);
      `CHK(tx_bit, b0[i])
    end
    for (int i = 0; i < 60000 && !u_mfts_if.irq; i++) @(negedge clk);
    `CHK(near(cyc - t0, HEAD_IRQ_BITS), 1'b1)
    @(negedge clk);
    wait_task(4000);
    @(posedge clk) rst <= 1'b1;
    tx_mode <= 1'b0;
    lres <= 2'($urandom_range(2));
    lbw <= 2'($urandom_range(2));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    q.push_back({mfts_pkg::TASK_SYNC, mfts_pkg::SYNC_BYTES});
    q.push_back({mfts_pkg::TASK_HSRCH, 5'h00});
    @(posedge clk) start_rx <= 1'b1;
    @(posedge clk) start_rx <= 1'b0;
    wait_task(4000);
    // Look after the level timeout and before the residual bandwidth step
    repeat (31 * B) @(posedge clk);
    @(negedge clk);
    lev_x = (t_srch - t_acq <= 28 * B) ? mfts_pkg::LEV_LOSSY
                                       : mfts_pkg::LEV_RESID;
    bw_x = (t_srch - t_acq <= 14 * B) ? mfts_pkg::BW_WIDE
                                      : mfts_pkg::BW_MEDIUM;
    `CHK(lev, lev_x)
    `CHK(bw, bw_x)
    `CHK(lev_res, lres)
    `CHK(bw_res, lbw)
    @(posedge clk) sync_found <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(lev, mfts_pkg::LEV_RESID)
    `CHK(bw == mfts_pkg::BW_WIDE, 1'b0)
    `CHK(q.size() == 0, 1'b1)
    end_sim();
  end
endmodule // mfts_tb
